// [design/dppc_top.sv]
`default_nettype none
// Summary of operation
// R1 - Port 0 high control resets to zero, pins seven to five inputs.
// R2 - Port 0 pin seven: input, open-drain, analog, timer-2 out, push-pull.
// R3 - Port 0 pin six: input, open-drain, analog, serial data out, push-pull.
// R4 - Port 0 high bit 0 set forces pin five push-pull, else middle field.
// R5 - Port 0 pin five: input, open-drain, analog, timer-1/PWM-1 out.
// R6 - Port 0 pin four: input, open-drain, analog, serial clock out, push-pull.
// R7 - Port 0 pin three: input, open-drain, analog, timer-0/PWM-0 out, push-pull.
// R8 - Software sets serial clock pin to input for serial slave use.
// R9 - Port 0 middle control resets to zero, pins four and three inputs.
// R10 - Port 0 pin two: input, open-drain, analog, push-pull; low resets zero.
// R11 - Port 0 pin one: input, open-drain, sub-oscillator output, push-pull.
// R12 - Port 0 pin zero: input, open-drain, sub-oscillator input, push-pull.
// R13 - One pull-up enable per port 0 pin, one enables, resets zero.
// R14 - Data reads pin level in input mode, drives pins in output mode.
// R15 - Port 1 high control resets to 01, pin four open-drain.
// R16 - Port 1 pin four: input, open-drain, unavailable, push-pull.
// R17 - Port 1 middle control resets to 20H.
// R18 - Port 1 pin three: input, open-drain, analog, PWM-4 out, push-pull.
// R19 - Port 1 pin two: input, open-drain, analog, PWM-3, buzzer, push-pull.
// R20 - Port 1 pin one: input, open-drain, analog, PWM-2, push-pull; low resets zero.
// R21 - Port 1 pin zero: input, open-drain, voltage reference, push-pull.
// R22 - Port 1 pull-up bits four to zero used, upper bits unused.
// R23 - Unused control bits ignore writes and read as zero.
module dppc_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [7:0] P0_PIN_IN,
  output logic [7:0] P0_PIN_OUT,
  output logic [7:0] P0_PIN_OE,
  output logic [7:0] P0_PULLUP,
  output logic [7:0] P0_ANALOG,
  output logic [7:0] P0_ALT_IN,
  input wire logic [4:0] P1_PIN_IN,
  output logic [4:0] P1_PIN_OUT,
  output logic [4:0] P1_PIN_OE,
  output logic [4:0] P1_PULLUP,
  output logic [4:0] P1_ANALOG,
  output logic [4:0] P1_ALT_IN,
  input wire logic TIMER2_OUTPUT,
  input wire logic SERIAL_DATA_OUTPUT,
  input wire logic TIMER1_PWM1_OUTPUT,
  input wire logic SERIAL_CLOCK_OUTPUT,
  input wire logic TIMER0_PWM0_OUTPUT,
  input wire logic SUB_OSCILLATOR_OUTPUT,
  input wire logic PWM_CHANNEL_FOUR_OUTPUT,
  input wire logic PWM_CHANNEL_THREE_OUTPUT,
  input wire logic BUZZER_OUTPUT,
  input wire logic PWM_CHANNEL_TWO_OUTPUT,
  output logic [7:0] P0_LEVEL,
  output logic [4:0] P1_LEVEL
);
  logic [7:0] p0_conh_q;
  logic [7:0] p0_conm_q;
  logic [7:0] p0_conl_q;
  logic [7:0] p0_pur_q;
  logic [7:0] p0_data_q;
  logic [7:0] p1_conh_q;
  logic [7:0] p1_conm_q;
  logic [7:0] p1_conl_q;
  logic [7:0] p1_pur_q;
  logic [7:0] p1_data_q;
  logic [7:0] p0_sync;
  logic [4:0] p1_sync;
  dppc_pkg::dppc_mode_e p0_mode [8];
  dppc_pkg::dppc_mode_e p1_mode [5];
  logic [7:0] p0_alt;
  logic [4:0] p1_alt;
  logic [7:0] p0_is_out;
  logic [4:0] p1_is_out;
  logic [7:0] rdata_d;

  // Three-bit field with analog at 010, a peripheral output at 011 and push-pull at 1xx.
  function automatic dppc_pkg::dppc_mode_e dec3(input logic [2:0] f);
    dppc_pkg::dppc_mode_e m;
    m = dppc_pkg::DPPC_PUSH_PULL;
    unique case (f[1:0])
      2'h0: m = f[2] ? dppc_pkg::DPPC_PUSH_PULL : dppc_pkg::DPPC_INPUT;
      2'h1: m = f[2] ? dppc_pkg::DPPC_PUSH_PULL : dppc_pkg::DPPC_OPEN_DRAIN;
      2'h2: m = f[2] ? dppc_pkg::DPPC_PUSH_PULL : dppc_pkg::DPPC_ANALOG;
      2'h3: m = f[2] ? dppc_pkg::DPPC_PUSH_PULL : dppc_pkg::DPPC_ALT_OUT;
    endcase
    return m;
  endfunction

  // Two-bit field whose code 10 selects the given alternative mode.
  function automatic dppc_pkg::dppc_mode_e dec2(input logic [1:0] f,
                                                input dppc_pkg::dppc_mode_e alt10);
    dppc_pkg::dppc_mode_e m;
    m = dppc_pkg::DPPC_INPUT;
    unique case (f)
      2'h0: m = dppc_pkg::DPPC_INPUT;
      2'h1: m = dppc_pkg::DPPC_OPEN_DRAIN;
      2'h2: m = alt10;
      2'h3: m = dppc_pkg::DPPC_PUSH_PULL;
    endcase
    return m;
  endfunction

  function automatic logic is_drive(input dppc_pkg::dppc_mode_e m);
    return (m == dppc_pkg::DPPC_PUSH_PULL) || (m == dppc_pkg::DPPC_OPEN_DRAIN);
  endfunction

  dppc_sync #(.WIDTH(8)) u_sync0 (
    .CLK(CLK),
    .RST(RST),
    .d(P0_PIN_IN),
    .q(p0_sync)
  );

  dppc_sync #(.WIDTH(5)) u_sync1 (
    .CLK(CLK),
    .RST(RST),
    .d(P1_PIN_IN),
    .q(p1_sync)
  );

  // R1 high reset
  // R9 middle reset
  // R10 low reset
  // R23 unused bits masked
  always_ff @(posedge CLK) begin
    if (RST) begin
      p0_conh_q <= dppc_pkg::RST_P0_CONH;
      p0_conm_q <= dppc_pkg::RST_P0_CONM;
      p0_conl_q <= dppc_pkg::RST_P0_CONL;
    end else if (WR) begin
      if (ADDR == dppc_pkg::ADDR_P0_CONH) p0_conh_q <= WDATA & dppc_pkg::MASK_P0_CONH;
      if (ADDR == dppc_pkg::ADDR_P0_CONM) p0_conm_q <= WDATA & dppc_pkg::MASK_P0_CONM;
      if (ADDR == dppc_pkg::ADDR_P0_CONL) p0_conl_q <= WDATA & dppc_pkg::MASK_P0_CONL;
    end
  end

  // R15 high resets 01
  // R17 middle resets 20H
  // R20 low resets zero
  // R23 unused bits masked
  always_ff @(posedge CLK) begin
    if (RST) begin
      p1_conh_q <= dppc_pkg::RST_P1_CONH;
      p1_conm_q <= dppc_pkg::RST_P1_CONM;
      p1_conl_q <= dppc_pkg::RST_P1_CONL;
    end else if (WR) begin
      if (ADDR == dppc_pkg::ADDR_P1_CONH) p1_conh_q <= WDATA & dppc_pkg::MASK_P1_CONH;
      if (ADDR == dppc_pkg::ADDR_P1_CONM) p1_conm_q <= WDATA & dppc_pkg::MASK_P1_CONM;
      if (ADDR == dppc_pkg::ADDR_P1_CONL) p1_conl_q <= WDATA & dppc_pkg::MASK_P1_CONL;
    end
  end

  // R13 port 0 pull-ups
  // R22 port 1 pull-ups
  always_ff @(posedge CLK) begin
    if (RST) begin
      p0_pur_q <= dppc_pkg::RST_P0_PUR;
      p1_pur_q <= dppc_pkg::RST_P1_PUR;
    end else if (WR) begin
      if (ADDR == dppc_pkg::ADDR_P0_PUR) p0_pur_q <= WDATA & dppc_pkg::MASK_P0_PUR;
      if (ADDR == dppc_pkg::ADDR_P1_PUR) p1_pur_q <= WDATA & dppc_pkg::MASK_P1_PUR;
    end
  end

  // R14 data latches
  always_ff @(posedge CLK) begin
    if (RST) begin
      p0_data_q <= dppc_pkg::RST_P0_DATA;
      p1_data_q <= dppc_pkg::RST_P1_DATA;
    end else if (WR) begin
      if (ADDR == dppc_pkg::ADDR_P0_DATA) p0_data_q <= WDATA;
      if (ADDR == dppc_pkg::ADDR_P1_DATA) p1_data_q <= WDATA & dppc_pkg::MASK_P1_DATA;
    end
  end

  always_comb begin
    // R2 pin seven
    p0_mode[7] = dec3(p0_conh_q[dppc_pkg::P0_PIN7_LSB +: 3]);
    // R3 pin six
    p0_mode[6] = dec3(p0_conh_q[dppc_pkg::P0_PIN6_LSB +: 3]);
    // R4 push-pull override
    // R5 middle field
    if (p0_conh_q[dppc_pkg::P0_PIN5_PP_BIT]) begin
      p0_mode[5] = dppc_pkg::DPPC_PUSH_PULL;
    end else if (p0_conm_q[dppc_pkg::P0_PIN5_LSB +: 2] == 2'h3) begin
      p0_mode[5] = dppc_pkg::DPPC_ALT_OUT;
    end else begin
      p0_mode[5] = dec2(p0_conm_q[dppc_pkg::P0_PIN5_LSB +: 2], dppc_pkg::DPPC_ANALOG);
    end
    // R6 pin four
    // R8 slave clock relies on input mode
    p0_mode[4] = dec3(p0_conm_q[dppc_pkg::P0_PIN4_LSB +: 3]);
    // R7 pin three
    p0_mode[3] = dec3(p0_conm_q[dppc_pkg::P0_PIN3_LSB +: 3]);
    // R10 pin two
    p0_mode[2] = dec2(p0_conl_q[dppc_pkg::P0_PIN2_LSB +: 2], dppc_pkg::DPPC_ANALOG);
    // R11 sub-oscillator output
    p0_mode[1] = dec2(p0_conl_q[dppc_pkg::P0_PIN1_LSB +: 2], dppc_pkg::DPPC_ALT_OUT);
    // R12 sub-oscillator input
    p0_mode[0] = dec2(p0_conl_q[dppc_pkg::P0_PIN0_LSB +: 2], dppc_pkg::DPPC_ALT_IN);
    // R16 code 10 unavailable
    p1_mode[4] = dec2(p1_conh_q[dppc_pkg::P1_PIN4_LSB +: 2], dppc_pkg::DPPC_NONE);
    // R18 pin three
    p1_mode[3] = dec3(p1_conm_q[dppc_pkg::P1_PIN3_LSB +: 3]);
    // R19 pin two sparse codes
    unique case (p1_conm_q[dppc_pkg::P1_PIN2_LSB +: 3])
      3'h0: p1_mode[2] = dppc_pkg::DPPC_INPUT;
      3'h1: p1_mode[2] = dppc_pkg::DPPC_OPEN_DRAIN;
      3'h2: p1_mode[2] = dppc_pkg::DPPC_ANALOG;
      3'h3: p1_mode[2] = dppc_pkg::DPPC_ALT_OUT;
      3'h5: p1_mode[2] = dppc_pkg::DPPC_ALT_OUT;
      3'h7: p1_mode[2] = dppc_pkg::DPPC_PUSH_PULL;
      default: p1_mode[2] = dppc_pkg::DPPC_NONE;
    endcase
    // R20 pin one
    p1_mode[1] = dec3(p1_conl_q[dppc_pkg::P1_PIN1_LSB +: 3]);
    // R21 voltage reference
    p1_mode[0] = dec2(p1_conl_q[dppc_pkg::P1_PIN0_LSB +: 2], dppc_pkg::DPPC_ANALOG);
  end

  always_comb begin
    p0_alt = {TIMER2_OUTPUT, SERIAL_DATA_OUTPUT, TIMER1_PWM1_OUTPUT, SERIAL_CLOCK_OUTPUT,
              TIMER0_PWM0_OUTPUT, 1'b0, SUB_OSCILLATOR_OUTPUT, 1'b0};
    p1_alt = {1'b0, PWM_CHANNEL_FOUR_OUTPUT,
              (p1_conm_q[dppc_pkg::P1_PIN2_LSB +: 3] == 3'h5) ? BUZZER_OUTPUT
                                                              : PWM_CHANNEL_THREE_OUTPUT,
              PWM_CHANNEL_TWO_OUTPUT, 1'b0};
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_p0
      assign p0_is_out[gi] = is_drive(p0_mode[gi]);
      dppc_pin u_pin (
        .CLK(CLK),
        .RST(RST),
        .mode(p0_mode[gi]),
        .data_bit(p0_data_q[gi]),
        .alt_bit(p0_alt[gi]),
        .pullup_bit(p0_pur_q[gi]),
        .pad_out(P0_PIN_OUT[gi]),
        .pad_oe(P0_PIN_OE[gi]),
        .pullup_on(P0_PULLUP[gi]),
        .analog_on(P0_ANALOG[gi]),
        .alt_in_on(P0_ALT_IN[gi])
      );
    end
    for (gi = 0; gi < 5; gi++) begin : g_p1
      assign p1_is_out[gi] = is_drive(p1_mode[gi]);
      dppc_pin u_pin (
        .CLK(CLK),
        .RST(RST),
        .mode(p1_mode[gi]),
        .data_bit(p1_data_q[gi]),
        .alt_bit(p1_alt[gi]),
        .pullup_bit(p1_pur_q[gi]),
        .pad_out(P1_PIN_OUT[gi]),
        .pad_oe(P1_PIN_OE[gi]),
        .pullup_on(P1_PULLUP[gi]),
        .analog_on(P1_ANALOG[gi]),
        .alt_in_on(P1_ALT_IN[gi])
      );
    end
  endgenerate

  // R14 read pin or latch
  always_comb begin
    rdata_d = 8'h00;
    unique case (ADDR)
      dppc_pkg::ADDR_P0_DATA: rdata_d = (p0_data_q & p0_is_out) | (p0_sync & ~p0_is_out);
      dppc_pkg::ADDR_P1_DATA: rdata_d = {3'h0, (p1_data_q[4:0] & p1_is_out)
                                               | (p1_sync & ~p1_is_out)};
      dppc_pkg::ADDR_P0_CONH: rdata_d = p0_conh_q;
      dppc_pkg::ADDR_P0_CONM: rdata_d = p0_conm_q;
      dppc_pkg::ADDR_P0_CONL: rdata_d = p0_conl_q;
      dppc_pkg::ADDR_P0_PUR: rdata_d = p0_pur_q;
      dppc_pkg::ADDR_P1_CONH: rdata_d = p1_conh_q;
      dppc_pkg::ADDR_P1_CONM: rdata_d = p1_conm_q;
      dppc_pkg::ADDR_P1_CONL: rdata_d = p1_conl_q;
      dppc_pkg::ADDR_P1_PUR: rdata_d = p1_pur_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data is registered, so software sees it one cycle after the strobe.
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
      P0_LEVEL <= 8'h00;
      P1_LEVEL <= 5'h00;
    end else begin
      if (RD) RDATA <= rdata_d;
      P0_LEVEL <= p0_sync;
      P1_LEVEL <= p1_sync;
    end
  end
endmodule
`default_nettype wire

// [design/dppc_pkg.sv]
`default_nettype none
package dppc_pkg;
  localparam logic [7:0] ADDR_P0_DATA = 8'hC0;
  localparam logic [7:0] ADDR_P1_DATA = 8'hC1;
  localparam logic [7:0] ADDR_P0_CONH = 8'hC6;
  localparam logic [7:0] ADDR_P0_CONM = 8'hC7;
  localparam logic [7:0] ADDR_P0_CONL = 8'hC8;
  localparam logic [7:0] ADDR_P0_PUR = 8'hC9;
  localparam logic [7:0] ADDR_P1_CONH = 8'hD3;
  localparam logic [7:0] ADDR_P1_CONM = 8'hD4;
  localparam logic [7:0] ADDR_P1_CONL = 8'hD5;
  localparam logic [7:0] ADDR_P1_PUR = 8'hD6;
  localparam logic [7:0] RST_P0_CONH = 8'h00;
  localparam logic [7:0] RST_P0_CONM = 8'h00;
  localparam logic [7:0] RST_P0_CONL = 8'h00;
  localparam logic [7:0] RST_P0_PUR = 8'h00;
  localparam logic [7:0] RST_P0_DATA = 8'h00;
  localparam logic [7:0] RST_P1_CONH = 8'h01;
  localparam logic [7:0] RST_P1_CONM = 8'h20;
  localparam logic [7:0] RST_P1_CONL = 8'h00;
  localparam logic [7:0] RST_P1_PUR = 8'h00;
  localparam logic [7:0] RST_P1_DATA = 8'h00;
  localparam logic [7:0] MASK_P0_CONH = 8'hFD;
  localparam logic [7:0] MASK_P0_CONM = 8'hFF;
  localparam logic [7:0] MASK_P0_CONL = 8'h3F;
  localparam logic [7:0] MASK_P0_PUR = 8'hFF;
  localparam logic [7:0] MASK_P1_CONH = 8'h03;
  localparam logic [7:0] MASK_P1_CONM = 8'hFC;
  localparam logic [7:0] MASK_P1_CONL = 8'h1F;
  localparam logic [7:0] MASK_P1_PUR = 8'h1F;
  localparam logic [7:0] MASK_P1_DATA = 8'h1F;
  localparam int P0_PIN7_LSB = 5;
  localparam int P0_PIN6_LSB = 2;
  localparam int P0_PIN5_PP_BIT = 0;
  localparam int P0_PIN5_LSB = 6;
  localparam int P0_PIN4_LSB = 3;
  localparam int P0_PIN3_LSB = 0;
  localparam int P0_PIN2_LSB = 4;
  localparam int P0_PIN1_LSB = 2;
  localparam int P0_PIN0_LSB = 0;
  localparam int P1_PIN4_LSB = 0;
  localparam int P1_PIN3_LSB = 5;
  localparam int P1_PIN2_LSB = 2;
  localparam int P1_PIN1_LSB = 2;
  localparam int P1_PIN0_LSB = 0;
  typedef enum logic [2:0] {
    DPPC_INPUT,
    DPPC_OPEN_DRAIN,
    DPPC_PUSH_PULL,
    DPPC_ANALOG,
    DPPC_ALT_OUT,
    DPPC_ALT_IN,
    DPPC_NONE
  } dppc_mode_e;
endpackage
`default_nettype wire

// [design/dppc_sync.sv]
`default_nettype none
module dppc_sync #(
  parameter int WIDTH = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [design/dppc_pin.sv]
`default_nettype none
module dppc_pin (
  input wire logic CLK,
  input wire logic RST,
  input wire dppc_pkg::dppc_mode_e mode,
  input wire logic data_bit,
  input wire logic alt_bit,
  input wire logic pullup_bit,
  output logic pad_out,
  output logic pad_oe,
  output logic pullup_on,
  output logic analog_on,
  output logic alt_in_on
);
  // Open-drain only ever drives low, so a one leaves the pad released.
  always_ff @(posedge CLK) begin
    if (RST) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pullup_on <= 1'b0;
      analog_on <= 1'b0;
      alt_in_on <= 1'b0;
    end else begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      unique case (mode)
        dppc_pkg::DPPC_PUSH_PULL: begin
          pad_out <= data_bit;
          pad_oe <= 1'b1;
        end
        dppc_pkg::DPPC_OPEN_DRAIN: begin
          pad_oe <= ~data_bit;
        end
        dppc_pkg::DPPC_ALT_OUT: begin
          pad_out <= alt_bit;
          pad_oe <= 1'b1;
        end
        dppc_pkg::DPPC_INPUT, dppc_pkg::DPPC_ANALOG, dppc_pkg::DPPC_ALT_IN,
        dppc_pkg::DPPC_NONE: begin
          pad_oe <= 1'b0;
        end
      endcase
      pullup_on <= pullup_bit & (mode != dppc_pkg::DPPC_ANALOG);
      analog_on <= (mode == dppc_pkg::DPPC_ANALOG);
      alt_in_on <= (mode == dppc_pkg::DPPC_ALT_IN);
    end
  end
endmodule
`default_nettype wire

// [dv/dppc_top_assertions.sv]
`default_nettype none
module dppc_top_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] P0_PIN_IN,
  input wire logic [7:0] P0_PIN_OE,
  input wire logic [7:0] P0_PULLUP,
  input wire logic [7:0] P0_ANALOG,
  input wire logic [7:0] P0_ALT_IN,
  input wire logic [4:0] P1_PIN_OE,
  input wire logic [4:0] P1_ANALOG,
  input wire logic [7:0] P0_LEVEL
);
  logic [2:0] age_q;
  logic mapped;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Level comparison waits until the synchroniser has refilled after reset.
  always_ff @(posedge CLK) begin
    if (RST) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  assign mapped = ADDR inside {8'hC0, 8'hC1, 8'hC6, 8'hC7, 8'hC8, 8'hC9,
    8'hD3, 8'hD4, 8'hD5, 8'hD6};
  a_rdata_hold: assert property (!RD |=> $stable(RDATA)) else $error("read data moved");
  a_unmapped_zero: assert property (RD && !mapped |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_unused_read: assert property (RD && ADDR == 8'hC6 |=> !RDATA[1])
    else $error("unused control bit read set");
  a_pin7_push: assert property (WR && ADDR == 8'hC6 && WDATA[7] |-> ##2 P0_PIN_OE[7])
    else $error("pin seven not driven");
  a_pin7_analog: assert property (WR && ADDR == 8'hC6 && WDATA[7:5] == 3'b010 |->
    ##2 P0_ANALOG[7] && !P0_PIN_OE[7]) else $error("pin seven not analog");
  a_pin5_force: assert property (WR && ADDR == 8'hC6 && WDATA[0] |-> ##2 P0_PIN_OE[5])
    else $error("pin five not forced");
  a_analog_quiet: assert property ((P0_ANALOG & P0_PIN_OE) == 8'h00)
    else $error("analog pin driven");
  a_analog_pullup: assert property ((P0_ANALOG & P0_PULLUP) == 8'h00)
    else $error("pull-up on analog pin");
  a_alt_in_only: assert property (P0_ALT_IN[7:1] == 7'h00)
    else $error("alternative input on wrong pin");
  a_reset_drive: assert property ($fell(RST) |-> ##1 P1_PIN_OE == 5'h18)
    else $error("second port reset drive wrong");
  a_pin14_none: assert property (WR && ADDR == 8'hD3 && WDATA[1:0] == 2'b10 |->
    ##2 !P1_PIN_OE[4] && !P1_ANALOG[4]) else $error("unavailable code drives");
  a_level_lag: assert property (age_q == 3'h7 |-> P0_LEVEL == $past(P0_PIN_IN, 3))
    else $error("pin level lag wrong");
endmodule
bind dppc_top dppc_top_assertions u_chk (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .P0_PIN_IN(P0_PIN_IN), .P0_PIN_OE(P0_PIN_OE),
  .P0_PULLUP(P0_PULLUP), .P0_ANALOG(P0_ANALOG), .P0_ALT_IN(P0_ALT_IN),
  .P1_PIN_OE(P1_PIN_OE), .P1_ANALOG(P1_ANALOG), .P0_LEVEL(P0_LEVEL));
`default_nettype wire

// [dv/dppc_board.sv]
`default_nettype none
module dppc_board #(
  parameter int W = 8
) (
  input wire logic CLK,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pu_en,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [W-1:0] churn_q = '0;
  // A floating pin with no pull-up churns so a stale level never reads as valid.
  always_ff @(posedge CLK) begin
    churn_q <= ~churn_q;
  end
  // pad level from drive, board source, pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & pu_en) | (~pin_oe & ~ext_en & ~pu_en & churn_q);
endmodule
`default_nettype wire

// [dv/dual_port_pin_control_tb.sv]
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module dual_port_pin_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wr, rd, per;
  logic [7:0] addr, wdata, rdata, p0_in, p0_out, p0_oe, p0_pu, p0_an, p0_ai, p0_lvl, ext0, ext0_en;
  logic [4:0] p1_in, p1_out, p1_oe, p1_pu, p1_an, p1_ai, p1_lvl, ext1, ext1_en;
  int fails, num_checks;
  localparam logic [23:0] REGS [10] = '{24'hC000FF, 24'hC1001F, 24'hC600FD, 24'hC700FF,
    24'hC8003F, 24'hC900FF, 24'hD30103, 24'hD420FC, 24'hD5001F, 24'hD6001F};
  localparam logic [7:0] CLR [6] = '{8'hC6, 8'hC7, 8'hC8, 8'hD3, 8'hD4, 8'hD5};
  localparam logic [23:0] MODES [56] = '{24'hC60070, 24'hC62071, 24'hC64073, 24'hC66074,
    24'hC68072, 24'hC6E072, 24'hC60461, 24'hC60863, 24'hC60C64, 24'hC61062, 24'hC74051,
    24'hC78053, 24'hC7C054, 24'hC70050, 24'hC70841, 24'hC71043, 24'hC71844, 24'hC72042,
    24'hC70131, 24'hC70233, 24'hC70334, 24'hC70432, 24'hC78053, 24'hC60152, 24'hC81021,
    24'hC82023, 24'hC83022, 24'hC80411, 24'hC80814, 24'hC80C12, 24'hC80101, 24'hC80205,
    24'hC80302, 24'hC80000, 24'hD300C0, 24'hD301C1, 24'hD302C6, 24'hD303C2, 24'hD420B1,
    24'hD440B3, 24'hD460B4, 24'hD480B2, 24'hD404A1, 24'hD408A3, 24'hD40CA4, 24'hD410A6,
    24'hD414A4, 24'hD418A6, 24'hD41CA2, 24'hD50491, 24'hD50893, 24'hD50C94, 24'hD51092,
    24'hD50181, 24'hD50283, 24'hD50382};
  dppc_top u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .P0_PIN_IN(p0_in), .P0_PIN_OUT(p0_out), .P0_PIN_OE(p0_oe),
    .P0_PULLUP(p0_pu), .P0_ANALOG(p0_an), .P0_ALT_IN(p0_ai), .P1_PIN_IN(p1_in),
    .P1_PIN_OUT(p1_out), .P1_PIN_OE(p1_oe), .P1_PULLUP(p1_pu), .P1_ANALOG(p1_an),
    .P1_ALT_IN(p1_ai), .TIMER2_OUTPUT(per), .SERIAL_DATA_OUTPUT(per),
    .TIMER1_PWM1_OUTPUT(per), .SERIAL_CLOCK_OUTPUT(per), .TIMER0_PWM0_OUTPUT(per),
    .SUB_OSCILLATOR_OUTPUT(per), .PWM_CHANNEL_FOUR_OUTPUT(per),
    .PWM_CHANNEL_THREE_OUTPUT(per), .BUZZER_OUTPUT(per), .PWM_CHANNEL_TWO_OUTPUT(per),
    .P0_LEVEL(p0_lvl), .P1_LEVEL(p1_lvl));
  dppc_board #(.W(8)) u_b0 (.CLK(clk), .pin_out(p0_out), .pin_oe(p0_oe), .pu_en(p0_pu),
    .ext_val(ext0), .ext_en(ext0_en), .pin_in(p0_in));
  dppc_board #(.W(5)) u_b1 (.CLK(clk), .pin_out(p1_out), .pin_oe(p1_oe), .pu_en(p1_pu),
    .ext_val(ext1), .ext_en(ext1_en), .pin_in(p1_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic conclude();
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Each access idles one cycle after it, so the strobe is never raised in the same step.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    `CHK($sformatf("read %h", a), exp, rdata)
    @(posedge clk);
    #1;
  endtask
  function automatic logic [4:0] pin_want(input logic [3:0] k, input logic d);
    case (k)
      4'h1: pin_want = {~d, 4'h1};
      4'h2: pin_want = {1'b1, d, 3'h1};
      4'h3: pin_want = 5'h04;
      4'h4: pin_want = {1'b1, ~d, 3'h1};
      4'h5: pin_want = 5'h03;
      default: pin_want = 5'h01;
    endcase
  endfunction
  task automatic t_reset();
    foreach (REGS[i]) rd_chk(REGS[i][23:16], REGS[i][15:8]);
    `CHK("port1 drive", 5'h18, p1_oe)
    `CHK("port0 drive", 8'h00, p0_oe)
  endtask
  task automatic t_masks();
    ext0_en = 8'h00;
    ext1_en = 5'h00;
    foreach (REGS[i]) wr_reg(REGS[i][23:16], 8'hFF);
    foreach (REGS[i]) rd_chk(REGS[i][23:16], REGS[i][7:0]);
    `CHK("port0 pullup", 8'hFF, p0_pu)
    `CHK("port1 pullup", 5'h1F, p1_pu)
    `CHK("port1 drive", 5'h1F, p1_oe)
    wr_reg(8'hC0, 8'hA5);
    `CHK("port0 out", 8'hA5, p0_out & p0_oe)
    rd_chk(8'hC0, 8'hA5);
    wr_reg(8'hC2, 8'h55);
    rd_chk(8'hC2, 8'h00);
    rd_chk(8'hCA, 8'h00);
  endtask
  task automatic t_modes();
    logic [23:0] e;
    logic [4:0] seen;
    logic [4:0] want;
    logic d;
    int p;
    foreach (CLR[i]) wr_reg(CLR[i], 8'h00);
    for (int pass = 0; pass < 2; pass++) begin
      d = pass[0];
      per = ~d;
      wr_reg(8'hC0, {8{d}});
      wr_reg(8'hC1, {8{d}});
      foreach (MODES[i]) begin
        e = MODES[i];
        wr_reg(e[23:16], e[15:8]);
        p = int'(e[6:4]);
        want = pin_want(e[3:0], d);
        if (e[7]) begin
          seen = {p1_oe[p], p1_out[p] & p1_oe[p], p1_an[p], p1_ai[p], p1_pu[p]};
          `CHK($sformatf("mode %h", e), want, seen)
        end else begin
          seen = {p0_oe[p], p0_out[p] & p0_oe[p], p0_an[p], p0_ai[p], p0_pu[p]};
          `CHK($sformatf("mode %h", e), want, seen)
        end
      end
    end
  endtask
  task automatic t_levels();
    foreach (CLR[i]) wr_reg(CLR[i], 8'h00);
    // pin four stays an input so an outside serial clock can enter.
    ext0 = 8'h3C;
    ext0_en = 8'hFF;
    ext1 = 5'h15;
    ext1_en = 5'h1F;
    repeat (4) @(posedge clk);
    #1;
    rd_chk(8'hC0, 8'h3C);
    rd_chk(8'hC1, 8'h15);
    `CHK("port0 level", 8'h3C, p0_lvl)
    `CHK("port1 level", 5'h15, p1_lvl)
    ext0_en = 8'h00;
    repeat (4) @(posedge clk);
    #1;
    rd_chk(8'hC0, 8'hFF);
  endtask
  initial begin
    #50000;
    fails++;
    conclude();
  end
  initial begin
    fails = 0;
    num_checks = 0;
    {rst, wr, rd, per} = 4'h8;
    {addr, wdata, ext0} = 24'h000000;
    ext1 = 5'h00;
    ext0_en = 8'hFF;
    ext1_en = 5'h07;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_masks();
    t_modes();
    t_levels();
    conclude();
  end
endmodule
`default_nettype wire
